// ==== component_interface_module.sv ====
/*
 * Priority logic for one plant component: merges safety and non-safety
 * demands, latches system-level actuation, gates remote station manual
 * controls, and returns component and internal status.
 * Assumes all inputs synchronous to clk and only discrete command bits
 * arriving from the remote I/O communication function.
 */
`timescale 1ns/10ps
`default_nettype none

module component_interface_module (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         nrst,
	// Safety port
	input  wire logic                         px_actuate,
	input  wire logic                         px_unactuate,
	input  wire logic                         sys_auto_actuate,
	input  wire logic                         man_actuate,
	input  wire logic                         man_reset,
	input  wire logic                         man_trip,
	input  wire logic                         man_block,
	input  wire logic                         trip_clear,
	input  wire logic                         block_permissive,
	input  wire logic                         block_removal,
	// Non-safety port
	input  wire logic                         py_actuate,
	input  wire logic                         py_unactuate,
	// Remote station
	input  wire logic [priority_pkg::REMOTE_W-1:0] remote_pos,
	input  wire logic [priority_pkg::REMOTE_W-1:0] remote_neg,
	input  wire logic                         xfer_enable,
	// Test
	input  wire logic                         test_request,
	input  wire logic                         test_interlock,
	// Component status in
	input  wire logic [priority_pkg::STAT_W-1:0] comp_status,
	// Outputs
	output logic                              comp_command,
	output logic                              sys_actuation,
	output logic                              reactor_trip,
	output logic                              block_active,
	output logic                              test_permit,
	output logic [priority_pkg::STAT_W-1:0]   status_comp,
	output logic [priority_pkg::INT_W-1:0]    status_internal
);
	import priority_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Remote station contact receiver

	contact_if #(.N(REMOTE_W)) remote_link ();

	pair_receiver #(
		.N (REMOTE_W)
	) u_rx (
		.clk  (clk),
		.nrst (nrst),
		.pos  (remote_pos),
		.neg  (remote_neg),
		.link (remote_link.rx)
	);

	////////////////////////////////////////////////////////////////////////
	// Input registers

	logic px_act_ff;
	logic px_unact_ff;
	logic py_act_ff;
	logic py_unact_ff;
	logic auto_ff;
	logic man_act_ff;
	logic man_reset_ff;
	logic man_trip_ff;
	logic man_block_ff;
	logic trip_clear_ff;
	logic permissive_ff;
	logic removal_ff;
	logic xfer_ff;
	logic test_req_ff;
	logic interlock_ff;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			px_act_ff     <= RST_BIT;
			px_unact_ff   <= RST_BIT;
			py_act_ff     <= RST_BIT;
			py_unact_ff   <= RST_BIT;
			auto_ff       <= RST_BIT;
			man_act_ff    <= RST_BIT;
			man_reset_ff  <= RST_BIT;
			man_trip_ff   <= RST_BIT;
			man_block_ff  <= RST_BIT;
			trip_clear_ff <= RST_BIT;
			permissive_ff <= RST_BIT;
			removal_ff    <= RST_BIT;
			xfer_ff       <= RST_BIT;
			test_req_ff   <= RST_BIT;
			interlock_ff  <= RST_BIT;
		end else begin
			px_act_ff     <= px_actuate;
			px_unact_ff   <= px_unactuate;
			py_act_ff     <= py_actuate;
			py_unact_ff   <= py_unactuate;
			auto_ff       <= sys_auto_actuate;
			man_act_ff    <= man_actuate;
			man_reset_ff  <= man_reset;
			man_trip_ff   <= man_trip;
			man_block_ff  <= man_block;
			trip_clear_ff <= trip_clear;
			permissive_ff <= block_permissive;
			removal_ff    <= block_removal;
			xfer_ff       <= xfer_enable;
			test_req_ff   <= test_request;
			interlock_ff  <= test_interlock;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// System-level decode

	logic    sys_ff;
	logic    trip_ff;
	logic    block_ff;
	logic    cmd_ff;
	logic    permit_ff;
	demand_t demand_ff;
	demand_t nxt_demand;

	wire remote_act;
	wire remote_trip;
	wire remote_block;
	wire remote_reset;
	wire auto_eff;
	wire sys_set;
	wire sys_clr;
	wire trip_set;
	wire blk_req;
	wire act_req;
	wire want_unact;
	wire nxt_sys;
	wire nxt_trip;
	wire nxt_block;
	wire nxt_permit;

	// Remote controls dead until operation is transferred
	assign remote_act   = xfer_ff & remote_link.contact[REMOTE_ACT];
	assign remote_trip  = xfer_ff & remote_link.contact[REMOTE_TRIP];
	assign remote_block = xfer_ff & remote_link.contact[REMOTE_BLOCK];
	assign remote_reset = xfer_ff & remote_link.contact[REMOTE_RESET];

	// Block only inhibits automatic actuation
	assign blk_req   = man_block_ff | remote_block;
	assign nxt_block = (block_ff | blk_req) & permissive_ff & ~removal_ff;
	assign auto_eff  = auto_ff & ~block_ff;

	// Set wins over reset, so manual actuation cannot be cancelled
	assign sys_set  = auto_eff | man_act_ff | remote_act;
	assign sys_clr  = man_reset_ff | remote_reset;
	assign nxt_sys  = sys_set | (sys_ff & ~sys_clr);
	assign trip_set = man_trip_ff | remote_trip;
	assign nxt_trip = trip_set | (trip_ff & ~trip_clear_ff);

	// Interlock touches nothing but the test permit
	assign nxt_permit = test_req_ff & interlock_ff;

	////////////////////////////////////////////////////////////////////////
	// Component demand arbitration

	assign act_req    = px_act_ff | py_act_ff | sys_ff | sys_set;
	assign want_unact = px_unact_ff | py_unact_ff;

	always_comb begin
		nxt_demand = demand_ff;
		unique case (demand_ff)
			DEM_UNACT: begin
				if (act_req)
					nxt_demand = DEM_ACT;
			end
			DEM_ACT: begin
				// Reset of the latch alone never moves the component
				if (!act_req && want_unact)
					nxt_demand = DEM_UNACT;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			demand_ff <= DEM_UNACT;
			cmd_ff    <= RST_BIT;
			sys_ff    <= RST_BIT;
			trip_ff   <= RST_BIT;
			block_ff  <= RST_BIT;
			permit_ff <= RST_BIT;
		end else begin
			demand_ff <= nxt_demand;
			cmd_ff    <= (nxt_demand == DEM_ACT);
			sys_ff    <= nxt_sys;
			trip_ff   <= nxt_trip;
			block_ff  <= nxt_block;
			permit_ff <= nxt_permit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status toward the non-safety side

	logic [STAT_W-1:0] stat_ff;
	logic [INT_W-1:0]  int_ff;
	wire  [INT_W-1:0]  nxt_int;

	assign nxt_int[INT_DEMAND] = cmd_ff;
	assign nxt_int[INT_SYSACT] = sys_ff;
	assign nxt_int[INT_BLOCK]  = block_ff;
	assign nxt_int[INT_FAULT]  = remote_link.fault;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			stat_ff <= RST_STATUS;
			int_ff  <= RST_INT;
		end else begin
			stat_ff <= comp_status;
			int_ff  <= nxt_int;
		end
	end

	assign comp_command    = cmd_ff;
	assign sys_actuation   = sys_ff;
	assign reactor_trip    = trip_ff;
	assign block_active    = block_ff;
	assign test_permit     = permit_ff;
	assign status_comp     = stat_ff;
	assign status_internal = int_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	act_wins_a : assert property (
		act_req |=> comp_command)
		else $error("actuate request did not actuate component");

	unact_only_a : assert property (
		(!act_req && want_unact) |=> !comp_command)
		else $error("unactuate without actuate did not unactuate");

	demand_hold_a : assert property (
		(!act_req && !want_unact) |=> $stable(comp_command))
		else $error("component moved with no demand present");

	reset_keeps_a : assert property (
		$fell(sys_actuation) |-> comp_command)
		else $error("system reset moved the component");

	unact_cause_a : assert property (
		$fell(comp_command) |-> $past(want_unact && !act_req))
		else $error("component unactuated without a command");

	remote_gate_a : assert property (
		($rose(sys_actuation) && !$past(xfer_ff)) |->
			$past(auto_eff || man_act_ff))
		else $error("remote actuation acted without transfer");

	no_cancel_a : assert property (
		sys_set |=> sys_actuation)
		else $error("actuation request was cancelled");

	block_perm_a : assert property (
		block_active |-> $past(permissive_ff && !removal_ff))
		else $error("block held without permissive");

	test_only_a : assert property (
		$rose(test_permit) |-> $past(test_interlock, 2))
		else $error("test permit without interlock");

	latency_a : assert property (
		($rose(px_actuate)) |=> ##1 comp_command)
		else $error("safety actuate not seen two edges later");

	status_a : assert property (
		$changed(comp_status) |=> (status_comp == $past(comp_status)))
		else $error("component status not returned");

	init_a : assert property (
		$rose(nrst) |-> !comp_command)
		else $error("demand not unactuated after reset");

	latched_hold_c : cover property (
		$fell(sys_actuation) ##[1:8] !comp_command);

	remote_act_c : cover property (
		xfer_ff && remote_act ##1 sys_actuation);

	block_c : cover property (
		$rose(block_active) ##[1:8] $fell(block_active));

endmodule : component_interface_module

`default_nettype wire

// ==== priority_pkg.sv ====
/*
 * Constants and types shared by the component priority logic.
 * Assumes nothing of its surroundings.
 */
package priority_pkg;

	// Remote station contact vector layout
	localparam int REMOTE_W     = 4;
	localparam int REMOTE_ACT   = 0;
	localparam int REMOTE_TRIP  = 1;
	localparam int REMOTE_BLOCK = 2;
	localparam int REMOTE_RESET = 3;

	// Status widths
	localparam int STAT_W = 4;
	localparam int INT_W  = 4;

	// Internal status field positions
	localparam int INT_DEMAND = 0;
	localparam int INT_SYSACT = 1;
	localparam int INT_BLOCK  = 2;
	localparam int INT_FAULT  = 3;

	// Reset values
	localparam logic                RST_BIT    = 1'h0;
	localparam logic [REMOTE_W-1:0] RST_REMOTE = 4'h0;
	localparam logic [STAT_W-1:0]   RST_STATUS = 4'h0;
	localparam logic [INT_W-1:0]    RST_INT    = 4'h0;

	// Stored component demand
	typedef enum logic {
		DEM_UNACT,
		DEM_ACT
	} demand_t;

endpackage : priority_pkg

// ==== contact_if.sv ====
/*
 * Carrier for decoded remote station contacts between receiver and
 * priority logic.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/10ps
`default_nettype none

interface contact_if #(
	parameter int N = 4
);
	logic [N-1:0] contact;
	logic         fault;

	modport rx (output contact, output fault);
	modport user (input contact, input fault);
endinterface : contact_if

`default_nettype wire

// ==== pair_receiver.sv ====
/*
 * Complementary pair receiver: each contact arrives as a true line and a
 * complement line; a contact state is taken only while both lines agree.
 * Assumes the pair inputs are synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none

module pair_receiver #(
	parameter int N = 4
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Contact pairs
	input  wire logic [N-1:0] pos,
	input  wire logic [N-1:0] neg,
	// Decoded contacts
	contact_if.rx             link
);
	import priority_pkg::*;

	if (N < 1 || N > 32) begin : g_bad_width
		$error("pair_receiver: N out of range");
	end

	logic [N-1:0] pos_ff;
	logic [N-1:0] neg_ff;
	logic [N-1:0] contact_ff;
	logic         fault_ff;
	wire  [N-1:0] agree;
	wire  [N-1:0] nxt_contact;
	wire          nxt_fault;

	// Lines agree when they are complementary
	assign agree       = pos_ff ^ neg_ff;
	assign nxt_contact = (agree & pos_ff) | (~agree & contact_ff);
	assign nxt_fault   = ~(&agree);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pos_ff     <= '0;
			neg_ff     <= '1;
			contact_ff <= '0;
			fault_ff   <= RST_BIT;
		end else begin
			pos_ff     <= pos;
			neg_ff     <= neg;
			contact_ff <= nxt_contact;
			fault_ff   <= nxt_fault;
		end
	end

	assign link.contact = contact_ff;
	assign link.fault   = fault_ff;

	////////////////////////////////////////////////////////////////////////

	pair_agree_a : assert property (@(posedge clk) disable iff (!nrst)
		$changed(contact_ff) |->
			(((contact_ff ^ $past(contact_ff)) & ~$past(pos_ff ^ neg_ff)) == '0))
		else $error("contact changed while its pair disagreed");

	pair_decode_a : assert property (@(posedge clk) disable iff (!nrst)
		(&(pos_ff ^ neg_ff)) |=> (contact_ff == $past(pos_ff)))
		else $error("agreeing pairs not reproduced on contacts");

endmodule : pair_receiver

`default_nettype wire

// ==== remote_node_controller_model.sv ====
/*
 * Far side model: remote I/O node and remote station transmitter.
 * Drives plain command bits and complementary contact pairs.
 * Assumes the bench sets its requests at the rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

module remote_node_controller_model (
	// Clock and reset
	input  wire logic                              clk,
	input  wire logic                              nrst,
	// Requests from the bench
	input  wire logic                              req_act,
	input  wire logic                              req_unact,
	input  wire logic [priority_pkg::REMOTE_W-1:0] contacts,
	input  wire logic [priority_pkg::REMOTE_W-1:0] corrupt,
	// Discrete lines toward the device
	output logic                                   py_actuate,
	output logic                                   py_unactuate,
	output logic [priority_pkg::REMOTE_W-1:0]      remote_pos,
	output logic [priority_pkg::REMOTE_W-1:0]      remote_neg
);
	import priority_pkg::*;

	// Only command bits leave the node, never framing or handshake
	always_ff @(posedge clk) begin
		if (!nrst) begin
			py_actuate   <= RST_BIT;
			py_unactuate <= RST_BIT;
			remote_pos   <= RST_REMOTE;
			remote_neg   <= ~RST_REMOTE;
		end else begin
			py_actuate   <= req_act;
			py_unactuate <= req_unact;
			remote_pos   <= contacts;
			remote_neg   <= ~contacts ^ corrupt;
		end
	end
endmodule : remote_node_controller_model

`default_nettype wire

// ==== component_interface_module_bench.sv ====
/*
 * Self-checking bench for the component priority logic.
 * Assumes the design and the far side model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module component_interface_module_bench;
	import priority_pkg::*;

	logic clk = 1'h0, nrst = 1'h0;
	logic px_actuate = 1'h0, px_unactuate = 1'h0, sys_auto_actuate = 1'h0;
	logic man_actuate = 1'h0, man_reset = 1'h0, man_trip = 1'h0;
	logic man_block = 1'h0, trip_clear = 1'h0, block_permissive = 1'h0;
	logic block_removal = 1'h0, xfer_enable = 1'h0, test_request = 1'h0;
	logic test_interlock = 1'h0, req_act = 1'h0, req_unact = 1'h0;
	logic [STAT_W-1:0] comp_status = 4'h0;
	logic [REMOTE_W-1:0] contacts = 4'h0, corrupt = 4'h0;
	logic [REMOTE_W-1:0] remote_pos, remote_neg;
	logic py_actuate, py_unactuate, comp_command, sys_actuation;
	logic reactor_trip, block_active, test_permit;
	logic [STAT_W-1:0] status_comp;
	logic [INT_W-1:0] status_internal;
	int n_errors = 0, comparisons = 0, cycles = 0;

	always #5 clk = ~clk;

	component_interface_module i_component_interface_module (
		.clk, .nrst, .px_actuate, .px_unactuate, .sys_auto_actuate,
		.man_actuate, .man_reset, .man_trip, .man_block,
		.trip_clear, .block_permissive, .block_removal, .py_actuate,
		.py_unactuate, .remote_pos, .remote_neg, .xfer_enable, .test_request,
		.test_interlock, .comp_status, .comp_command, .sys_actuation,
		.reactor_trip, .block_active, .test_permit, .status_comp,
		.status_internal
	);

	remote_node_controller_model i_remote_node_controller_model (
		.clk, .nrst, .req_act, .req_unact, .contacts, .corrupt,
		.py_actuate, .py_unactuate, .remote_pos, .remote_neg
	);

	////////////////////////////////////////////////////////////////////
	task go(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : go

	task chk_bit(input logic g, input logic e);
		comparisons++;
		if (g !== e) begin
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
			n_errors++;
		end
	endtask : chk_bit

	task chk_vec(input logic [3:0] g, input logic [3:0] e);
		comparisons++;
		if (g !== e) begin
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
			n_errors++;
		end
	endtask : chk_vec

	task end_sim;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	// Hang guard, far above the length of the sequence
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			n_errors++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'h1;
		go(1);
		chk_bit(comp_command, 1'h0);
		chk_vec({sys_actuation, reactor_trip, block_active, test_permit},
			4'h0);
		chk_vec(status_internal, 4'h0);
		// Latency, actuate and hold
		@(posedge clk) px_actuate <= 1'h1;
		go(1);
		chk_bit(comp_command, 1'h0);
		go(1);
		chk_bit(comp_command, 1'h1);
		@(posedge clk) px_actuate <= 1'h0;
		go(4);
		chk_bit(comp_command, 1'h1);
		chk_bit(status_internal[INT_DEMAND], 1'h1);
		// Non-safety actuate beats safety unactuate, both arriving together
		@(posedge clk) req_act <= 1'h1;
		@(posedge clk) px_unactuate <= 1'h1;
		go(2);
		chk_bit(comp_command, 1'h1);
		go(3);
		chk_bit(comp_command, 1'h1);
		@(posedge clk) req_act <= 1'h0;
		go(5);
		chk_bit(comp_command, 1'h0);
		@(posedge clk) px_unactuate <= 1'h0;
		req_act <= 1'h1;
		go(5);
		chk_bit(comp_command, 1'h1);
		@(posedge clk) req_act <= 1'h0;
		req_unact <= 1'h1;
		go(5);
		chk_bit(comp_command, 1'h0);
		// System actuation, reset leaves the component actuated
		@(posedge clk) req_unact <= 1'h0;
		sys_auto_actuate <= 1'h1;
		go(2);
		chk_bit(sys_actuation, 1'h1);
		chk_bit(comp_command, 1'h1);
		@(posedge clk) sys_auto_actuate <= 1'h0;
		man_reset <= 1'h1;
		go(2);
		chk_bit(sys_actuation, 1'h0);
		chk_bit(comp_command, 1'h1);
		@(posedge clk) man_reset <= 1'h0;
		go(4);
		chk_bit(comp_command, 1'h1);
		@(posedge clk) req_unact <= 1'h1;
		go(5);
		chk_bit(comp_command, 1'h0);
		// Manual actuation and trip win against reset and clear
		@(posedge clk) req_unact <= 1'h0;
		man_actuate <= 1'h1;
		man_reset <= 1'h1;
		man_trip <= 1'h1;
		trip_clear <= 1'h1;
		go(2);
		chk_bit(sys_actuation, 1'h1);
		chk_bit(reactor_trip, 1'h1);
		@(posedge clk) man_actuate <= 1'h0;
		man_trip <= 1'h0;
		go(3);
		chk_bit(sys_actuation, 1'h0);
		chk_bit(reactor_trip, 1'h0);
		// Block needs permissive, stops automatic, removed automatically
		@(posedge clk) man_reset <= 1'h0;
		trip_clear <= 1'h0;
		man_block <= 1'h1;
		go(3);
		chk_bit(block_active, 1'h0);
		@(posedge clk) block_permissive <= 1'h1;
		go(3);
		chk_bit(block_active, 1'h1);
		chk_bit(status_internal[INT_BLOCK], 1'h1);
		@(posedge clk) sys_auto_actuate <= 1'h1;
		go(3);
		chk_bit(sys_actuation, 1'h0);
		@(posedge clk) block_removal <= 1'h1;
		go(3);
		chk_bit(block_active, 1'h0);
		chk_bit(sys_actuation, 1'h1);
		// Test interlock gates the permit only
		@(posedge clk) test_request <= 1'h1;
		go(3);
		chk_bit(test_permit, 1'h0);
		@(posedge clk) test_interlock <= 1'h1;
		go(3);
		chk_bit(test_permit, 1'h1);
		chk_bit(status_internal[INT_SYSACT], 1'h1);
		@(posedge clk) test_interlock <= 1'h0;
		sys_auto_actuate <= 1'h0;
		man_block <= 1'h0;
		man_reset <= 1'h1;
		go(3);
		chk_bit(test_permit, 1'h0);
		chk_bit(sys_actuation, 1'h0);
		// Remote station contacts through the pair receiver
		@(posedge clk) man_reset <= 1'h0;
		contacts <= 4'h1;
		go(6);
		chk_bit(sys_actuation, 1'h0);
		@(posedge clk) xfer_enable <= 1'h1;
		go(6);
		chk_bit(sys_actuation, 1'h1);
		@(posedge clk) contacts <= 4'h8;
		go(6);
		chk_bit(sys_actuation, 1'h0);
		@(posedge clk) contacts <= 4'h2;
		corrupt <= 4'h2;
		go(6);
		chk_bit(reactor_trip, 1'h0);
		chk_bit(status_internal[INT_FAULT], 1'h1);
		@(posedge clk) corrupt <= 4'h0;
		go(6);
		chk_bit(reactor_trip, 1'h1);
		chk_bit(status_internal[INT_FAULT], 1'h0);
		// Remote block contact, honoured while the permissive stands
		@(posedge clk) block_removal <= 1'h0;
		contacts <= 4'h4;
		go(6);
		chk_bit(block_active, 1'h1);
		// Component status returned outward
		@(posedge clk) comp_status <= 4'ha;
		go(1);
		chk_vec(status_comp, 4'ha);
		@(posedge clk) comp_status <= 4'h5;
		go(1);
		chk_vec(status_comp, 4'h5);
		end_sim();
	end
endmodule : component_interface_module_bench

`default_nettype wire
